// [common/pdgc_pkg.sv]
package pdgc_pkg;

    // counter geometry
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;

    // register byte offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PRESET = 4'h4;
    localparam logic [3:0] ADDR_VALUE = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;

    // control field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_GATE_EN = 1;
    localparam int CTRL_GATE_RISE = 2;
    localparam int CTRL_REPEAT = 3;
    localparam int CTRL_W = 4;

    // status field positions
    localparam int STAT_OVF = 0;
    localparam int STAT_UDF = 1;
    localparam int STAT_RUN = 4;
    localparam int STAT_HALT = 5;
    localparam int STAT_WAIT = 6;

    // reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [7:0] PRESET_RST = 8'h33;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        PDGC_IDLE,
        PDGC_WAIT,
        PDGC_RUN,
        PDGC_HALT
    } pdgc_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic lvl_d;
    } pdgc_sync_t;

    typedef struct packed {
        logic [7:0] cnt;
        pdgc_state_t st;
        logic en_d;
        logic [3:0] ctl;
        logic [7:0] preset;
        logic ovf_p;
        logic udf_p;
        logic ovf_s;
        logic udf_s;
        logic [31:0] rdata;
    } pdgc_regs_t;

endpackage : pdgc_pkg

// [rtl/pdgc_sync.sv]
`timescale 1ns/1ps
module pdgc_sync
    import pdgc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);

    pdgc_sync_t r;
    pdgc_sync_t nxt;

    // three stages; level moves only once stages two and three agree
    always_comb
    begin
        nxt = r;
        nxt.s1 = pin_in;
        nxt.s2 = r.s1;
        nxt.s3 = r.s2;
        nxt.lvl_d = r.lvl;
        if (r.s2 == r.s3)
        begin
            nxt.lvl = r.s3;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= nxt;
        end
    end

    // edge pulses last exactly one cycle
    assign level_out = r.lvl;
    assign rise_out = r.lvl & ~r.lvl_d;
    assign fall_out = ~r.lvl & r.lvl_d;

endmodule : pdgc_sync

// [rtl/pdgc_top.sv]
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - each pulse on the count pulse input moves the counter by one.
// - the direction input level picks increment or decrement per pulse.
// - no pulse is counted before the channel enable is set.
// - repetitive mode reloads the preset on wrap and keeps counting.
// - count-once mode reloads the preset on wrap and then halts.
// - falling-edge gate mode starts on a falling edge, later ones retrigger.
// - in falling-edge gate mode counting stops while the gate is high.
// - rising-edge gate mode starts on a rising edge, no retrigger.
module pdgc_top
    import pdgc_pkg::*;
#(
    parameter int APB_AW = 8
)
(
    input wire logic REF_CLK_IN,
    input wire logic RESET_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [APB_AW-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic COUNT_PULSE_INPUT_IN,
    input wire logic DIRECTION_INPUT_IN,
    input wire logic GATE_INPUT_IN,
    output logic [CNT_W-1:0] CHANNEL_ZERO_COUNTER_OUT,
    output logic OVERFLOW_OUT,
    output logic UNDERFLOW_OUT
);

    pdgc_regs_t r;
    pdgc_regs_t n;

    logic pulse_rise;
    logic dir_lvl;
    logic gate_lvl;
    logic gate_rise_p;
    logic gate_fall_p;

    // pin conditioning, one instance per pin
    pdgc_sync u_pulse (
        .clk_in(REF_CLK_IN),
        .rst_in(RESET_IN),
        .pin_in(COUNT_PULSE_INPUT_IN),
        .level_out(),
        .rise_out(pulse_rise),
        .fall_out()
    );

    pdgc_sync u_dir (
        .clk_in(REF_CLK_IN),
        .rst_in(RESET_IN),
        .pin_in(DIRECTION_INPUT_IN),
        .level_out(dir_lvl),
        .rise_out(),
        .fall_out()
    );

    pdgc_sync u_gate (
        .clk_in(REF_CLK_IN),
        .rst_in(RESET_IN),
        .pin_in(GATE_INPUT_IN),
        .level_out(gate_lvl),
        .rise_out(gate_rise_p),
        .fall_out(gate_fall_p)
    );

    // apb decode; only four aligned words at the bottom are mapped
    logic [3:0] word_addr;
    logic mapped;
    logic wr_acc;
    logic rd_setup;

    assign word_addr = PADDR_IN[3:0];
    assign mapped = (PADDR_IN[APB_AW-1:4] == '0) && (PADDR_IN[1:0] == 2'b00);
    assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN & mapped;
    assign rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;

    // control decode
    logic en;
    logic en_rise;
    logic gate_en;
    logic fall_mode;
    logic rise_mode;
    logic fall_trig;
    logic rise_trig;
    logic gate_ok;
    logic step;
    logic wrap_up;
    logic wrap_dn;

    assign en = r.ctl[CTRL_ENABLE];
    assign en_rise = en & ~r.en_d;
    assign gate_en = r.ctl[CTRL_GATE_EN];
    assign fall_mode = gate_en & ~r.ctl[CTRL_GATE_RISE];
    assign rise_mode = gate_en & r.ctl[CTRL_GATE_RISE];
    // any falling edge restarts, whether waiting, running or halted
    assign fall_trig = en & ~en_rise & fall_mode & gate_fall_p;
    // rising start only from the waiting state, never again after
    assign rise_trig = en & ~en_rise & rise_mode & gate_rise_p
        & (r.st == PDGC_WAIT);
    assign gate_ok = ~(fall_mode & gate_lvl);
    assign step = en & ~en_rise & ~fall_trig & (r.st == PDGC_RUN)
        & pulse_rise & gate_ok;
    assign wrap_up = step & dir_lvl & (r.cnt == CNT_MAX);
    assign wrap_dn = step & ~dir_lvl & (r.cnt == CNT_ZERO);

    // next state of the whole block
    always_comb
    begin
        n = r;
        n.ovf_p = 1'b0;
        n.udf_p = 1'b0;
        n.en_d = en;
        // register writes take effect at the access edge
        if (wr_acc && word_addr == ADDR_CTRL)
        begin
            n.ctl = PWDATA_IN[CTRL_W-1:0];
        end
        if (wr_acc && word_addr == ADDR_PRESET)
        begin
            n.preset = PWDATA_IN[CNT_W-1:0];
        end
        // counter sequencing, priority top down
        if (!en)
        begin
            n.st = PDGC_IDLE;
        end
        else if (en_rise)
        begin
            n.cnt = r.preset;
            n.st = gate_en ? PDGC_WAIT : PDGC_RUN;
        end
        else if (fall_trig)
        begin
            n.cnt = r.preset;
            n.st = PDGC_RUN;
        end
        else if (rise_trig)
        begin
            n.st = PDGC_RUN;
        end
        else if (fall_mode && gate_lvl && r.st == PDGC_RUN)
        begin
            n.st = PDGC_WAIT;
        end
        else if (wrap_up || wrap_dn)
        begin
            n.cnt = r.preset;
            n.ovf_p = wrap_up;
            n.udf_p = wrap_dn;
            n.st = r.ctl[CTRL_REPEAT] ? PDGC_RUN : PDGC_HALT;
        end
        else if (step)
        begin
            n.cnt = dir_lvl ? r.cnt + CNT_ONE : r.cnt - CNT_ONE;
        end
        // sticky flags: a wrap in the clearing cycle still sets the flag
        n.ovf_s = (r.ovf_s & ~(wr_acc && word_addr == ADDR_STATUS
            && PWDATA_IN[STAT_OVF])) | n.ovf_p;
        n.udf_s = (r.udf_s & ~(wr_acc && word_addr == ADDR_STATUS
            && PWDATA_IN[STAT_UDF])) | n.udf_p;
        // read data captured in setup so it comes from a flop
        if (rd_setup)
        begin
            n.rdata = RDATA_RST;
            unique case (word_addr)
                ADDR_CTRL: n.rdata[CTRL_W-1:0] = r.ctl;
                ADDR_PRESET: n.rdata[CNT_W-1:0] = r.preset;
                ADDR_VALUE: n.rdata[CNT_W-1:0] = r.cnt;
                ADDR_STATUS:
                begin
                    n.rdata[STAT_OVF] = r.ovf_s;
                    n.rdata[STAT_UDF] = r.udf_s;
                    n.rdata[STAT_RUN] = (r.st == PDGC_RUN);
                    n.rdata[STAT_HALT] = (r.st == PDGC_HALT);
                    n.rdata[STAT_WAIT] = (r.st == PDGC_WAIT);
                end
                default: n.rdata = RDATA_RST;
            endcase
            // upper words would alias the low ones, so refused reads are forced to zero
            if (!mapped)
            begin
                n.rdata = RDATA_RST;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RESET_IN)
        begin
            r.cnt <= COUNT_RST;
            r.st <= PDGC_IDLE;
            r.en_d <= 1'b0;
            r.ctl <= CTRL_RST;
            r.preset <= PRESET_RST;
            r.ovf_p <= 1'b0;
            r.udf_p <= 1'b0;
            r.ovf_s <= 1'b0;
            r.udf_s <= 1'b0;
            r.rdata <= RDATA_RST;
        end
        else
        begin
            r <= n;
        end
    end

    // zero wait states; unmapped words answer with an error
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
    assign PRDATA_OUT = r.rdata;
    assign CHANNEL_ZERO_COUNTER_OUT = r.cnt;
    assign OVERFLOW_OUT = r.ovf_p;
    assign UNDERFLOW_OUT = r.udf_p;

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    // a wrap followed by the reload cycle
    sequence s_wrap_once;
        (wrap_up || wrap_dn) && !r.ctl[CTRL_REPEAT];
    endsequence

    sequence s_reload_halt;
        (r.cnt == $past(r.preset)) && (r.st == PDGC_HALT);
    endsequence

    AST_STEP_ONE: assert property (
        (step && dir_lvl && r.cnt != CNT_MAX) |=> r.cnt == $past(r.cnt) + CNT_ONE)
        else $error("up step did not add one");

    AST_STEP_DOWN: assert property (
        (step && !dir_lvl && r.cnt != CNT_ZERO)
        |=> r.cnt == $past(r.cnt) - CNT_ONE)
        else $error("down step did not subtract one");

    AST_NO_COUNT_DISABLED: assert property (
        (!en) |=> $stable(r.cnt) && !OVERFLOW_OUT && !UNDERFLOW_OUT)
        else $error("counter moved while disabled");

    AST_REPEAT_RELOAD: assert property (
        ((wrap_up || wrap_dn) && r.ctl[CTRL_REPEAT])
        |=> (r.cnt == $past(r.preset)) && (r.st == PDGC_RUN))
        else $error("repetitive wrap did not reload and run");

    AST_ONCE_HALT: assert property (
        s_wrap_once |=> s_reload_halt ##1 (!en || fall_trig || $stable(r.cnt)))
        else $error("count-once wrap did not reload and halt");

    AST_FALL_START: assert property (
        fall_trig |=> (r.st == PDGC_RUN) && (r.cnt == $past(r.preset)))
        else $error("falling gate edge did not restart");

    AST_FALL_STOP: assert property (
        (en && !en_rise && fall_mode && gate_lvl) |=> $stable(r.cnt))
        else $error("counted while gate high in falling mode");

    AST_RISE_NO_RETRIG: assert property (
        (en && !en_rise && rise_mode && r.st == PDGC_RUN && gate_rise_p
        && !step) |=> (r.st == PDGC_RUN) && $stable(r.cnt))
        else $error("rising gate mode was retriggered");

    AST_OVF_FLAG: assert property (
        wrap_up |=> OVERFLOW_OUT && !UNDERFLOW_OUT && r.ovf_s ##1 !OVERFLOW_OUT)
        else $error("overflow pulse missing or too long");

    AST_UDF_FLAG: assert property (
        (step && !dir_lvl && r.cnt == CNT_ZERO) |=> UNDERFLOW_OUT
        && r.cnt == $past(r.preset))
        else $error("underflow below zero not flagged");

endmodule : pdgc_top

// [verification/pdgc_pulse_src.sv]
`timescale 1ns/1ps
// behavioural source of count pulses and direction level
module pdgc_pulse_src
(
    input wire logic clk_in,
    output logic pulse_out,
    output logic dir_out
);
    // idle levels, pulse low and direction up
    initial
    begin
        pulse_out = 1'b0;
        dir_out = 1'b1;
    end

    // direction settles 4 cycles ahead of each rise, wide high and low
    // phases so the pin synchroniser never misses an edge
    task send(input logic up, input int n);
        repeat (n)
        begin
            dir_out <= up;
            repeat (4) @(posedge clk_in);
            pulse_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            pulse_out <= 1'b0;
            repeat (8) @(posedge clk_in);
        end
    endtask : send
endmodule : pdgc_pulse_src

// [verification/pdgc_top_tb.sv]
`timescale 1ns/1ps
module pdgc_top_tb;
    import pdgc_pkg::*;
    logic clk, rst, psel, penable, pwrite, gate;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, pulse, dir, ovf, udf;
    logic [7:0] cnt;
    int n_fail = 0;
    int n_checks = 0;
    int n_ovf = 0;
    int n_udf = 0;

    pdgc_top i_pdgc_top (.REF_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .COUNT_PULSE_INPUT_IN(pulse),
        .DIRECTION_INPUT_IN(dir), .GATE_INPUT_IN(gate),
        .CHANNEL_ZERO_COUNTER_OUT(cnt), .OVERFLOW_OUT(ovf),
        .UNDERFLOW_OUT(udf));
    pdgc_pulse_src i_pdgc_pulse_src (.clk_in(clk), .pulse_out(pulse),
        .dir_out(dir));

    // one-cycle wrap pulses counted mid-cycle, clear of the launching edge
    always @(negedge clk)
    begin
        if (ovf === 1'b1) n_ovf++;
        if (udf === 1'b1) n_udf++;
    end

    task give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            n_fail++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, {4'h0, a}, d, q, e);
        repeat (2) @(posedge clk);
    endtask : wr

    task rd(input logic [3:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, {4'h0, a}, 32'h0000_0000, q, e);
        chk(q, x);
        chk({31'h0, e}, 32'h0000_0000);
    endtask : rd

    task cnt_is(input logic [7:0] x);
        chk({24'h0, cnt}, {24'h0, x});
    endtask : cnt_is

    task set_gate(input logic v);
        gate <= v;
        repeat (8) @(posedge clk);
    endtask : set_gate

    // reset values, read-only value word, unmapped place
    task t_regs();
        logic [31:0] q;
        logic e;
        rd(ADDR_CTRL, 32'h0000_0000);
        rd(ADDR_PRESET, 32'h0000_0033);
        wr(ADDR_VALUE, 32'h0000_0055);
        rd(ADDR_VALUE, 32'h0000_0000);
        apb(1'b0, 8'h02, 32'h0000_0000, q, e);
        chk({31'h0, e}, 32'h0000_0001);
        // an upper word must not alias the preset word
        apb(1'b0, 8'h14, 32'h0000_0000, q, e);
        chk(q, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
    endtask : t_regs

    // pulses before enable are dropped
    task t_disabled();
        i_pdgc_pulse_src.send(1'b1, 2);
        cnt_is(8'h00);
    endtask : t_disabled

    // repetitive wrap past all ones reloads and keeps counting
    task t_repeat();
        wr(ADDR_PRESET, 32'h0000_00FE);
        wr(ADDR_CTRL, 32'h0000_0009);
        cnt_is(8'hFE);
        i_pdgc_pulse_src.send(1'b1, 2);
        cnt_is(8'hFE);
        chk(n_ovf, 1);
        i_pdgc_pulse_src.send(1'b1, 1);
        cnt_is(8'hFF);
        wr(ADDR_CTRL, 32'h0000_0000);
    endtask : t_repeat

    // count-once wrap below zero reloads and halts
    task t_once();
        wr(ADDR_PRESET, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0001);
        i_pdgc_pulse_src.send(1'b0, 1);
        cnt_is(8'h00);
        i_pdgc_pulse_src.send(1'b0, 1);
        cnt_is(8'h01);
        chk(n_udf, 1);
        i_pdgc_pulse_src.send(1'b0, 2);
        rd(ADDR_VALUE, 32'h0000_0001);
        rd(ADDR_STATUS, 32'h0000_0023);
        wr(ADDR_STATUS, 32'h0000_0003);
        rd(ADDR_STATUS, 32'h0000_0020);
        wr(ADDR_CTRL, 32'h0000_0000);
    endtask : t_once

    // falling gate starts, high gate stops, next fall reloads
    task t_gate_fall();
        wr(ADDR_PRESET, 32'h0000_0033);
        wr(ADDR_CTRL, 32'h0000_000B);
        i_pdgc_pulse_src.send(1'b1, 1);
        cnt_is(8'h33);
        set_gate(1'b0);
        i_pdgc_pulse_src.send(1'b1, 2);
        cnt_is(8'h35);
        set_gate(1'b1);
        i_pdgc_pulse_src.send(1'b1, 1);
        cnt_is(8'h35);
        rd(ADDR_STATUS, 32'h0000_0040);
        set_gate(1'b0);
        cnt_is(8'h33);
        wr(ADDR_CTRL, 32'h0000_0000);
    endtask : t_gate_fall

    // rising gate starts once; later gate edges change nothing
    task t_gate_rise();
        wr(ADDR_CTRL, 32'h0000_000F);
        i_pdgc_pulse_src.send(1'b0, 1);
        cnt_is(8'h33);
        set_gate(1'b1);
        i_pdgc_pulse_src.send(1'b0, 1);
        cnt_is(8'h32);
        set_gate(1'b0);
        i_pdgc_pulse_src.send(1'b0, 1);
        set_gate(1'b1);
        cnt_is(8'h31);
        rd(ADDR_STATUS, 32'h0000_0010);
    endtask : t_gate_rise

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        gate = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        t_regs();
        t_disabled();
        t_repeat();
        t_once();
        t_gate_fall();
        t_gate_rise();
        give_verdict();
    end
endmodule : pdgc_top_tb
